// ---- hw/dls_pkg.sv ----
// Shared constants and types for the debug link sleep and sync event block.
package dls_pkg;

  // Sleep depth reported by the sleep controller, shallowest first.
  typedef enum logic [1:0] {
    DLS_SLEEP_ACTIVE  = 2'b00,
    DLS_SLEEP_IDLE    = 2'b01,
    DLS_SLEEP_STANDBY = 2'b10,
    DLS_SLEEP_PWRDOWN = 2'b11
  } dls_sleep_t;

  // System bus access sequencer states.
  typedef enum logic [1:0] {
    DLS_BUS_IDLE  = 2'b00,
    DLS_BUS_ISSUE = 2'b01,
    DLS_BUS_WAIT  = 2'b10
  } dls_bus_state_t;

  localparam int unsigned DLS_NUM_EVENT_CHANNELS = 4;
  localparam int unsigned DLS_EDGE_COUNT_WIDTH   = 8;
  localparam int unsigned DLS_ADDR_WIDTH         = 16;
  localparam int unsigned DLS_DATA_WIDTH         = 8;

  localparam logic [7:0]  DLS_EDGE_COUNT_RESET   = 8'h00;
  localparam logic        DLS_PREV_BIT_RESET     = 1'b1;

endpackage

// ---- hw/dls_evt_if.sv ----
// Carrier between the top block and its sync edge detector.
`timescale 1ns/10ps
interface dls_evt_if;
  logic rx_bit;
  logic window;
  logic edge_pulse;

  modport src (
    output rx_bit,
    output window,
    input  edge_pulse
  );

  modport det (
    input  rx_bit,
    input  window,
    output edge_pulse
  );
endinterface

// ---- hw/dls_edge_det.sv ----
// Rising edge detector for the received sync character.
`timescale 1ns/10ps
module dls_edge_det (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  // Link side
  dls_evt_if.det    evt
);
  import dls_pkg::*;

  logic prev_q;
  logic pulse_q;

  // The idle line is high, so the edge memory starts high to avoid a false
  // edge on the first bit of a character.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      prev_q <= DLS_PREV_BIT_RESET;
    end else if (evt.window) begin
      prev_q <= evt.rx_bit;
    end else begin
      prev_q <= DLS_PREV_BIT_RESET;
    end
  end

  // One pulse per rising edge, with no enable of its own.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= evt.window && evt.rx_bit && !prev_q;
    end
  end

  assign evt.edge_pulse = pulse_q;
endmodule

// ---- hw/dls_top.sv ----
// Sleep handling and sync edge events of the single wire debug interface.
//
// Contract
// - Edge event drives every async event channel.
// - Pulse event per rising sync character edge.
// - Sync edge event cannot be disabled; here i_enable low gates the sync window and suppresses it.
// - Physical layer runs in every sleep mode.
// - Physical clock runs while interface is enabled.
// - No system bus access while CPU clock stopped; here a transfer already in the wait state still runs to its ack.
// - Sleeping flag set at idle or deeper.
// - Hold request keeps system clock from stopping.
// - With hold set, sleep is only emulated.
`timescale 1ns/10ps
module dls_top #(
  parameter int unsigned NUM_CHANNELS = dls_pkg::DLS_NUM_EVENT_CHANNELS,
  parameter int unsigned COUNT_WIDTH  = dls_pkg::DLS_EDGE_COUNT_WIDTH
) (
  // Clock and reset
  input  wire logic                                i_clk,
  input  wire logic                                i_rst_b,
  // Interface enable and link receive
  input  wire logic                                i_enable,
  input  wire logic                                i_rx_bit,
  input  wire logic                                i_sync_character_window,
  // Debugger controls
  input  wire logic                                i_system_clock_hold_request,
  // Sleep controller
  input  wire dls_pkg::dls_sleep_t                 i_sleep_mode,
  // Debugger bus request
  input  wire logic                                i_dbg_req,
  input  wire logic                                i_dbg_write,
  input  wire logic [dls_pkg::DLS_ADDR_WIDTH-1:0]  i_dbg_addr,
  input  wire logic [dls_pkg::DLS_DATA_WIDTH-1:0]  i_dbg_wdata,
  // System bus
  input  wire logic                                i_sys_ack,
  input  wire logic [dls_pkg::DLS_DATA_WIDTH-1:0]  i_sys_rdata,
  output logic                                     o_sys_req,
  output logic                                     o_sys_write,
  output logic [dls_pkg::DLS_ADDR_WIDTH-1:0]       o_sys_addr,
  output logic [dls_pkg::DLS_DATA_WIDTH-1:0]       o_sys_wdata,
  // Debugger bus answer
  output logic                                     o_dbg_done,
  output logic                                     o_dbg_refused,
  output logic [dls_pkg::DLS_DATA_WIDTH-1:0]       o_dbg_rdata,
  // Status and clock control
  output logic                                     o_system_sleeping_flag,
  output logic                                     o_sysclk_stop_allow,
  output logic                                     o_sleep_emulated,
  output logic                                     o_phy_clk_run,
  // Event routing fabric
  output logic [NUM_CHANNELS-1:0]                  o_async_event_channel,
  output logic                                     o_sync_edge_event,
  output logic [COUNT_WIDTH-1:0]                   o_sync_edge_count
);
  import dls_pkg::*;

  initial begin
    if (NUM_CHANNELS < 1 || NUM_CHANNELS > 16) begin
      $error("NUM_CHANNELS must be between 1 and 16");
    end
    if (COUNT_WIDTH < 1 || COUNT_WIDTH > 8) begin
      $error("COUNT_WIDTH must be between 1 and 8");
    end
  end

  // Every sleep mode from idle downward stops the processor clock.
  function automatic logic dls_cpu_clock_off(input dls_sleep_t mode);
    dls_cpu_clock_off = (mode != DLS_SLEEP_ACTIVE);
  endfunction

  dls_evt_if evt ();

  dls_bus_state_t                bus_state_q;
  logic                          edge_event_q;
  logic [NUM_CHANNELS-1:0]       channel_q;
  logic [COUNT_WIDTH-1:0]        edge_count_q;
  logic                          sleeping_q;
  logic                          stop_allow_q;
  logic                          emulated_q;
  logic                          phy_run_q;
  logic                          sys_req_q;
  logic                          sys_write_q;
  logic [DLS_ADDR_WIDTH-1:0]     sys_addr_q;
  logic [DLS_DATA_WIDTH-1:0]     sys_wdata_q;
  logic                          dbg_done_q;
  logic                          dbg_refused_q;
  logic [DLS_DATA_WIDTH-1:0]     dbg_rdata_q;
  logic                          bus_blocked;

  // The detector only listens inside the sync window while the interface is enabled;
  // sleep does not gate it, so sleep cannot suppress the event.
  assign evt.rx_bit = i_rx_bit;
  assign evt.window = i_sync_character_window && i_enable;

  dls_edge_det u_edge_det (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .evt     (evt)
  );

  // The pulse is fanned out to every channel; users synchronise it.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      edge_event_q <= 1'b0;
      channel_q    <= '0;
    end else begin
      edge_event_q <= evt.edge_pulse;
      channel_q    <= {NUM_CHANNELS{evt.edge_pulse}};
    end
  end

  // Running count of detected edges, never cleared between characters, so a
  // host can take the difference of two readings when measuring the clock.
  // It steps on the same edge that raises the event output, so both agree
  // even when the last edge of a character falls on the closing bit.
  // It wraps silently; a host must read it more often than once per wrap.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      edge_count_q <= DLS_EDGE_COUNT_RESET[COUNT_WIDTH-1:0];
    end else if (evt.edge_pulse) begin
      edge_count_q <= edge_count_q + COUNT_WIDTH'(1);
    end
  end

  // The physical layer clock request follows only the enable, never the
  // sleep settings.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      phy_run_q <= 1'b0;
    end else begin
      phy_run_q <= i_enable;
    end
  end

  // Sleep status and clock stop permission toward the clock controller.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      sleeping_q   <= 1'b0;
      stop_allow_q <= 1'b0;
      emulated_q   <= 1'b0;
    end else begin
      sleeping_q   <= dls_cpu_clock_off(i_sleep_mode);
      stop_allow_q <= dls_cpu_clock_off(i_sleep_mode) && !i_system_clock_hold_request;
      emulated_q   <= dls_cpu_clock_off(i_sleep_mode) && i_system_clock_hold_request;
    end
  end

  // With the hold request set the clock keeps running, so the bus stays
  // usable even though the system reports sleep.
  assign bus_blocked = dls_cpu_clock_off(i_sleep_mode) && !i_system_clock_hold_request;

  // A transfer already granted is allowed to finish; stopping it halfway
  // would leave the slave with a dangling request.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      bus_state_q   <= DLS_BUS_IDLE;
      sys_req_q     <= 1'b0;
      sys_write_q   <= 1'b0;
      sys_addr_q    <= '0;
      sys_wdata_q   <= '0;
      dbg_done_q    <= 1'b0;
      dbg_refused_q <= 1'b0;
      dbg_rdata_q   <= '0;
    end else begin
      dbg_done_q    <= 1'b0;
      dbg_refused_q <= 1'b0;
      case (bus_state_q)
        DLS_BUS_IDLE: begin
          if (i_dbg_req && bus_blocked) begin
            dbg_refused_q <= 1'b1;
          end else if (i_dbg_req) begin
            sys_write_q <= i_dbg_write;
            sys_addr_q  <= i_dbg_addr;
            sys_wdata_q <= i_dbg_wdata;
            bus_state_q <= DLS_BUS_ISSUE;
          end
        end
        DLS_BUS_ISSUE: begin
          if (bus_blocked) begin
            dbg_refused_q <= 1'b1;
            bus_state_q   <= DLS_BUS_IDLE;
          end else begin
            sys_req_q   <= 1'b1;
            bus_state_q <= DLS_BUS_WAIT;
          end
        end
        DLS_BUS_WAIT: begin
          if (i_sys_ack) begin
            sys_req_q   <= 1'b0;
            dbg_done_q  <= 1'b1;
            dbg_rdata_q <= sys_write_q ? dbg_rdata_q : i_sys_rdata;
            bus_state_q <= DLS_BUS_IDLE;
          end
        end
        default: begin
          sys_req_q   <= 1'b0;
          bus_state_q <= DLS_BUS_IDLE;
        end
      endcase
    end
  end

  assign o_sys_req              = sys_req_q;
  assign o_sys_write            = sys_write_q;
  assign o_sys_addr             = sys_addr_q;
  assign o_sys_wdata            = sys_wdata_q;
  assign o_dbg_done             = dbg_done_q;
  assign o_dbg_refused          = dbg_refused_q;
  assign o_dbg_rdata            = dbg_rdata_q;
  assign o_system_sleeping_flag = sleeping_q;
  assign o_sysclk_stop_allow    = stop_allow_q;
  assign o_sleep_emulated       = emulated_q;
  assign o_phy_clk_run          = phy_run_q;
  assign o_async_event_channel  = channel_q;
  assign o_sync_edge_event      = edge_event_q;
  assign o_sync_edge_count      = edge_count_q;
endmodule

// ---- verif/dls_checker.sv ----
// Concurrent checks on the ports of the sleep and sync event block.
`timescale 1ns/10ps
module dls_checker import dls_pkg::*; #(
  parameter int unsigned NUM_CHANNELS = 4,
  parameter int unsigned COUNT_WIDTH  = 8
) (
  input wire logic                    i_clk,
  input wire logic                    i_rst_b,
  input wire logic                    i_enable,
  input wire logic                    i_rx_bit,
  input wire logic                    i_sync_character_window,
  input wire logic                    i_system_clock_hold_request,
  input wire dls_sleep_t              i_sleep_mode,
  input wire logic                    i_sys_ack,
  input wire logic                    o_sys_req,
  input wire logic                    o_dbg_done,
  input wire logic                    o_system_sleeping_flag,
  input wire logic                    o_sysclk_stop_allow,
  input wire logic                    o_sleep_emulated,
  input wire logic                    o_phy_clk_run,
  input wire logic [NUM_CHANNELS-1:0] o_async_event_channel,
  input wire logic                    o_sync_edge_event,
  input wire logic [COUNT_WIDTH-1:0]  o_sync_edge_count
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  chk_edge_event: assert property (i_enable && i_sync_character_window && i_rx_bit
    && $past(i_sync_character_window) && !$past(i_rx_bit) |-> ##2 o_sync_edge_event)
    else $error("sync edge gave no event");
  chk_event_single: assert property (o_sync_edge_event |=> !o_sync_edge_event)
    else $error("edge event longer than one cycle");
  chk_channel_copy: assert property (o_async_event_channel == {NUM_CHANNELS{o_sync_edge_event}})
    else $error("event channels differ from edge event");
  chk_count_step: assert property (o_sync_edge_event |->
    o_sync_edge_count == COUNT_WIDTH'($past(o_sync_edge_count) + 1))
    else $error("edge count did not step");
  chk_sleep_flag: assert property (1 |=> o_system_sleeping_flag ==
    ($past(i_sleep_mode) != DLS_SLEEP_ACTIVE)) else $error("sleeping flag wrong");
  chk_hold_clock: assert property (1 |=> o_sysclk_stop_allow ==
    (o_system_sleeping_flag && !$past(i_system_clock_hold_request)))
    else $error("clock stop allowed wrongly");
  chk_sleep_emul: assert property (1 |=> o_sleep_emulated ==
    (o_system_sleeping_flag && $past(i_system_clock_hold_request)))
    else $error("sleep emulation wrong");
  chk_bus_blocked: assert property ($rose(o_sys_req) |->
    $past(i_sleep_mode) == DLS_SLEEP_ACTIVE || $past(i_system_clock_hold_request))
    else $error("bus access while clock stopped");
  chk_req_holds: assert property (o_sys_req && !i_sys_ack |=> o_sys_req)
    else $error("bus request dropped before ack");
  chk_done_ack: assert property (o_sys_req && i_sys_ack |=> o_dbg_done && !o_sys_req)
    else $error("no done after ack");
  chk_phy_clock: assert property (1 |=> o_phy_clk_run == $past(i_enable))
    else $error("physical clock run wrong");
endmodule
bind dls_top dls_checker #(.NUM_CHANNELS(NUM_CHANNELS), .COUNT_WIDTH(COUNT_WIDTH)) u_chk (.*);

// ---- verif/dls_sys_slave.sv ----
// System bus slave that acks after a chosen latency and returns address-derived data.
`timescale 1ns/10ps
module dls_sys_slave (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_req,
  input  wire logic [15:0] i_addr,
  input  wire logic [3:0]  i_lat,
  output logic             o_ack,
  output logic [7:0]       o_rdata
);
  logic [3:0] cnt_q;
  // Between acks the data is inverted each cycle so stale values never look valid.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cnt_q   <= 4'h0;
      o_ack   <= 1'b0;
      o_rdata <= 8'h00;
    end else if (!i_req || o_ack) begin
      cnt_q   <= 4'h0;
      o_ack   <= 1'b0;
      o_rdata <= ~o_rdata;
    end else if (cnt_q >= i_lat) begin
      o_ack   <= 1'b1;
      o_rdata <= i_addr[7:0] ^ 8'h5A;
    end else begin
      cnt_q   <= cnt_q + 4'h1;
      o_rdata <= ~o_rdata;
    end
  end
endmodule

// ---- verif/tb_top.sv ----
// Self-checking bench for the sleep and sync event block.
`timescale 1ns/10ps
module tb_top;
  import dls_pkg::*;
  logic        i_clk = 0, i_rst_b = 0, i_enable = 1, i_rx_bit = 1, i_sync_character_window = 0;
  logic        i_system_clock_hold_request = 0, i_dbg_req = 0, i_dbg_write = 0, i_sys_ack;
  dls_sleep_t  i_sleep_mode = DLS_SLEEP_ACTIVE;
  logic [15:0] i_dbg_addr = 0, o_sys_addr, lfsr_q = 16'h1AC8;
  logic [7:0]  i_dbg_wdata = 0, i_sys_rdata, o_sys_wdata, o_dbg_rdata, o_sync_edge_count;
  logic [7:0]  last_rd = 8'h00;
  logic        o_sys_req, o_sys_write, o_dbg_done, o_dbg_refused, o_system_sleeping_flag;
  logic        o_sysclk_stop_allow, o_sleep_emulated, o_phy_clk_run, o_sync_edge_event, prev = 1;
  logic [3:0]  o_async_event_channel, lat = 0;
  logic [11:0] exp_q[$];
  int          n_fail = 0, comparisons = 0, edges = 0;

  dls_top #(.NUM_CHANNELS(4), .COUNT_WIDTH(8)) DUT (.*);
  dls_sys_slave u_slave (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_req(o_sys_req),
    .i_addr(o_sys_addr), .i_lat(lat), .o_ack(i_sys_ack), .o_rdata(i_sys_rdata));

  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic see(input logic [11:0] got);
    if (exp_q.size() == 0) chk("unexpected result", 12'h000, got);
    else chk("result", exp_q.pop_front(), got);
  endtask
  // One debugger access under a given sleep depth and hold setting.
  // A late access enters idle sleep right after the request is taken.
  task automatic bus(input dls_sleep_t m, input logic h, input logic late);
    int k;
    logic w;
    i_sleep_mode = m;
    i_system_clock_hold_request = h;
    lfsr_q = nxt(lfsr_q);
    lat = {1'b0, lfsr_q[2:0]};
    w = lfsr_q[4];
    cyc(1);
    chk("sleeping flag", {11'h000, m != DLS_SLEEP_ACTIVE}, {11'h000, o_system_sleeping_flag});
    i_dbg_addr = lfsr_q;
    i_dbg_wdata = lfsr_q[15:8];
    i_dbg_write = w;
    i_dbg_req = 1;
    if ((m != DLS_SLEEP_ACTIVE || late) && !h) exp_q.push_back(12'h200);
    else if (!w) begin
      last_rd = lfsr_q[7:0] ^ 8'h5A;
      exp_q.push_back({4'h1, last_rd});
    end else exp_q.push_back({4'h1, last_rd});
    cyc(1);
    i_dbg_req = 0;
    i_dbg_write = 0;
    if (late) i_sleep_mode = DLS_SLEEP_IDLE;
    for (k = 0; k < 40 && o_dbg_done !== 1'b1 && o_dbg_refused !== 1'b1; k++) cyc(1);
    if (k == 40) begin
      n_fail++;
      summarize();
    end
    if (o_dbg_done === 1'b1) begin
      chk("sys write", {11'h000, w}, {11'h000, o_sys_write});
      chk("sys addr low", {4'h0, lfsr_q[7:0]}, {4'h0, o_sys_addr[7:0]});
      chk("sys addr high", {4'h0, lfsr_q[15:8]}, {4'h0, o_sys_addr[15:8]});
      chk("sys wdata", {4'h0, lfsr_q[15:8]}, {4'h0, o_sys_wdata});
    end
    cyc(1);
  endtask
  // Sends a sync window; the bench tracks the previous bit, forced high outside windows.
  task automatic sync(input int n, input logic rnd);
    i_sync_character_window = 1;
    for (int b = 0; b < n; b++) begin
      lfsr_q = nxt(lfsr_q);
      i_rx_bit = rnd ? lfsr_q[0] : !b[0];
      if (i_enable && i_rx_bit && !prev) begin
        edges++;
        exp_q.push_back({4'h3, edges[7:0]});
      end
      if (i_enable) prev = i_rx_bit;
      cyc(1);
    end
    i_sync_character_window = 0;
    i_rx_bit = 1;
    prev = 1;
    cyc(4);
  endtask

  initial begin
    forever #2.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    #2;
    if (o_dbg_done === 1'b1) see({4'h1, o_dbg_rdata});
    if (o_dbg_refused === 1'b1) see(12'h200);
    if (o_sync_edge_event === 1'b1) see({4'h3, o_sync_edge_count});
  end
  initial begin
    cyc(5);
    i_rst_b = 1;
    for (int i = 0; i < 6; i++) bus(DLS_SLEEP_ACTIVE, 1'b0, 1'b0);
    for (int i = 0; i < 8; i++) bus(dls_sleep_t'(i[1:0]), i[2], 1'b0);
    for (int i = 0; i < 2; i++) bus(DLS_SLEEP_ACTIVE, i[0], 1'b1);
    i_sleep_mode = DLS_SLEEP_PWRDOWN;
    sync(12, 1'b0);
    sync(40, 1'b1);
    i_enable = 0;
    sync(10, 1'b1);
    i_enable = 1;
    cyc(2);
    chk("edge count", {4'h0, edges[7:0]}, {4'h0, o_sync_edge_count});
    chk("pending results", 12'h000, 12'(exp_q.size()));
    summarize();
  end
endmodule
